// ===== logic/bpsk_stream_codec.sv
// What this block does
// - BPSK receive sub-carrier selectable from fc/16 to fc/4.
// - Reporting period spans one to eight sub-carrier periods.
// - First period with sub-carrier raises receive start and stores first bit.
// - Bit is 0 for the initial phase, 1 for inverted phase.
// - End of receive on the first period without sub-carrier.
// - Field value 01b gives fc/8 and two periods per report.
// - Transmit is the same for both receive variants, bits from FIFO.
// - Transmit period field sets how long each FIFO bit drives the modulator.
// - Bit 0 leaves carrier alone, bit 1 modulates with AM or OOK.
// - Transmit period value 000b gives 128 carrier cycles per bit.
// - Registers use a 6-bit address, 00h to 3Fh.
// - Set Default restores registers except both IO and operation control.
// - Configuration registers read and write; display registers read-only.
// - First bit sent or received sits in the byte's LSB.
// - Mode register selects stream mode; stream register holds its options.
`include "codec_regs.svh"
`default_nettype none
module bpsk_stream_codec
    import codec_pkg::*;
(
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic fc_tick_in,
    input  wire logic rx_subc_in,
    input  wire logic ss_n_in,
    input  wire logic sclk_in,
    input  wire logic mosi_in,
    output logic      miso_out,
    output logic      miso_oe_out,
    output logic      tx_mod_out,
    output logic      tx_ook_out,
    output logic      rx_start_out,
    output logic      rx_end_out
);

    // ----------------------------------------
    // Period decoding
    // ----------------------------------------
    function automatic logic [7:0] subc_len(input logic [1:0] f);
        subc_len = (f == 2'h3) ? `SUBC_MIN : (`SUBC_BASE >> f);
    endfunction

    function automatic logic [7:0] rep_len(input logic [1:0] f, input logic [1:0] p);
        rep_len = subc_len(f) << p;
    endfunction

    function automatic logic [7:0] tx_len(input logic [2:0] s);
        tx_len = `TX_BASE >> s;
    endfunction

    // Unmapped addresses share this so that they neither store nor read back.
    function automatic logic is_ro(input logic [5:0] a);
        is_ro = a inside {[6'h17:6'h1C], 6'h1F, 6'h20, 6'h23, 6'h25, 6'h28,
                          [6'h2B:6'h2D], 6'h2F, 6'h30, 6'h34, 6'h35, 6'h38,
                          6'h39, [6'h3C:6'h3F]};
    endfunction

    codec_st_t  st_ff;
    codec_st_t  nxt_st;
    logic [1:0] scf;
    logic [1:0] scp;
    logic [7:0] sl;
    logic [7:0] rl;
    logic [7:0] tl;
    logic [7:0] nper;
    logic       stream;
    logic       f_in_valid;
    logic       f_in_ready;
    logic [7:0] f_in_data;
    logic       f_out_valid;
    logic       f_out_ready;
    logic [7:0] f_out_data;
    logic [5:0] f_count;
    logic       spi_push;
    logic       spi_pop;
    logic       tx_take;
    logic       cmd_tx;
    logic       cmd_def;
    logic       wr_en;
    logic [7:0] byte_b;
    logic [7:0] pop_b;
    logic [7:0] ag;
    logic [7:0] ed;
    logic       rxs;
    logic       refb;
    logic       car;
    logic       ph;
    logic       rbit;

    assign scf    = st_ff.regs[`A_STREAM][`STR_SCF];
    assign scp    = st_ff.regs[`A_STREAM][`STR_SCP];
    assign sl     = subc_len(scf);
    assign rl     = rep_len(scf, scp);
    assign tl     = tx_len(st_ff.regs[`A_STREAM][`STR_STX]);
    assign nper   = 8'h01 << scp;
    assign stream = st_ff.regs[`A_MODE][`MODE_OM] == `OM_STREAM;

    function automatic logic [7:0] rd_byte(input logic [5:0] a);
        if (a == `A_FSTAT1) begin
            rd_byte = {2'h0, f_count};
        end else if (a == `A_FSTAT2) begin
            rd_byte = {st_ff.ovf, st_ff.pend, st_ff.cs == ST_TX, st_ff.cs == ST_RX,
                       1'b0, st_ff.rxn};
        end else if (is_ro(a)) begin
            rd_byte = 8'h00;
        end else begin
            rd_byte = st_ff.regs[a];
        end
    endfunction

    // ----------------------------------------
    // Shared data FIFO
    // ----------------------------------------
    // A finished receive byte waits in pend while the FIFO is full, so the
    // receiver never drops silently; a second byte meanwhile flags overflow.
    assign f_in_valid  = spi_push | st_ff.pend;
    assign f_in_data   = spi_push ? byte_b : st_ff.pbyte;
    assign f_out_ready = spi_pop | tx_take;

    stream_fifo #(
        .W (8),
        .D (32)
    ) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_in        (rst_in),
        .in_valid_in   (f_in_valid),
        .in_ready_out  (f_in_ready),
        .in_data_in    (f_in_data),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data),
        .count_out     (f_count)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        spi_push = 1'b0;
        spi_pop = 1'b0;
        tx_take = 1'b0;
        cmd_tx = 1'b0;
        cmd_def = 1'b0;
        wr_en = 1'b0;
        pop_b = 8'h00;
        car = 1'b0;
        ph = 1'b0;
        rbit = 1'b0;
        nxt_st.start = 1'b0;
        nxt_st.endp = 1'b0;
        nxt_st.pin.ss = {st_ff.pin.ss[0], ss_n_in};
        nxt_st.pin.sck = {st_ff.pin.sck[1:0], sclk_in};
        nxt_st.pin.mosi = {st_ff.pin.mosi[0], mosi_in};
        nxt_st.pin.rx = {st_ff.pin.rx[1:0], rx_subc_in};
        byte_b = {st_ff.spi.shi[6:0], st_ff.pin.mosi[1]};
        rxs = st_ff.pin.rx[1];
        refb = ~|(st_ff.fcnt & (sl >> 1));
        ag = st_ff.agree + {7'h0, rxs == refb};
        ed = st_ff.edges + {7'h0, rxs ^ st_ff.pin.rx[2]};

        // SPI slave: sample on falling SCLK, shift out on rising SCLK.
        if (st_ff.pin.ss[1]) begin
            nxt_st.spi.first = 1'b1;
            nxt_st.spi.bitcnt = 3'h0;
            nxt_st.moe = 1'b0;
        end else begin
            nxt_st.moe = 1'b1;
            if (st_ff.pin.sck[1] && !st_ff.pin.sck[2]) begin
                if (!st_ff.spi.first && st_ff.spi.op == `OP_FIFO && st_ff.spi.addr[0]
                    && st_ff.spi.bitcnt == 3'h0) begin
                    spi_pop = f_out_valid;
                    pop_b = f_out_valid ? f_out_data : 8'h00;
                    nxt_st.miso = pop_b[7];
                    nxt_st.spi.sho = {pop_b[6:0], 1'b0};
                end else begin
                    nxt_st.miso = st_ff.spi.sho[7];
                    nxt_st.spi.sho = {st_ff.spi.sho[6:0], 1'b0};
                end
            end
            if (!st_ff.pin.sck[1] && st_ff.pin.sck[2]) begin
                nxt_st.spi.shi = byte_b;
                nxt_st.spi.bitcnt = st_ff.spi.bitcnt + 3'h1;
                if (st_ff.spi.bitcnt == 3'h7) begin
                    if (st_ff.spi.first) begin
                        nxt_st.spi.first = 1'b0;
                        nxt_st.spi.op = byte_b[7:6];
                        nxt_st.spi.addr = byte_b[5:0];
                        nxt_st.spi.sho = rd_byte(byte_b[5:0]);
                        if (byte_b[7:6] == `OP_CMD) begin
                            cmd_def = byte_b[5:0] == `CMD_SET_DEFAULT;
                            cmd_tx = byte_b[5:0] == `CMD_TX_CRC
                                  || byte_b[5:0] == `CMD_TX_NOCRC;
                        end
                    end else begin
                        unique case (st_ff.spi.op)
                            `OP_WR: begin
                                wr_en = !is_ro(st_ff.spi.addr);
                                nxt_st.spi.addr = st_ff.spi.addr + 6'h01;
                            end
                            `OP_RD: begin
                                nxt_st.spi.addr = st_ff.spi.addr + 6'h01;
                                nxt_st.spi.sho = rd_byte(st_ff.spi.addr + 6'h01);
                            end
                            `OP_FIFO: begin
                                spi_push = !st_ff.spi.addr[0];
                            end
                            `OP_CMD: begin
                            end
                        endcase
                    end
                end
            end
        end

        if (wr_en) begin
            nxt_st.regs[st_ff.spi.addr] = byte_b;
        end
        if (cmd_def) begin
            for (int i = 3; i < 64; i++) begin
                nxt_st.regs[i] = `REG_RST;
            end
        end
        if (st_ff.spi.first == 1'b0 && st_ff.spi.op == `OP_RD
            && st_ff.spi.addr == `A_FSTAT2 && wr_en == 1'b0 && cmd_def == 1'b0
            && st_ff.pin.sck[1] && !st_ff.pin.sck[2] && st_ff.spi.bitcnt == 3'h0) begin
            nxt_st.ovf = 1'b0;
        end
        if (st_ff.pend && !spi_push && f_in_ready) begin
            nxt_st.pend = 1'b0;
        end
        if (spi_push && !f_in_ready) begin
            nxt_st.ovf = 1'b1;
        end

        // Codec state machine; the receive side runs whenever stream mode idles.
        nxt_st.ook = st_ff.regs[`A_MODE][`MODE_OOK];
        unique case (st_ff.cs)
            ST_IDLE: begin
                nxt_st.mod = 1'b0;
                nxt_st.fcnt = 8'h00;
                nxt_st.agree = 8'h00;
                nxt_st.edges = 8'h00;
                nxt_st.rxn = 3'h0;
                nxt_st.rxsh = 8'h00;
                if (stream) begin
                    nxt_st.cs = ST_HUNT;
                end
            end
            ST_HUNT, ST_RX: begin
                nxt_st.edges = ed;
                if (fc_tick_in) begin
                    nxt_st.agree = ag;
                    nxt_st.fcnt = st_ff.fcnt + 8'h01;
                    if (st_ff.fcnt == rl - 8'h01) begin
                        nxt_st.fcnt = 8'h00;
                        nxt_st.agree = 8'h00;
                        nxt_st.edges = 8'h00;
                        car = ed >= nper;
                        ph = ag < (rl >> 1);
                        rbit = (st_ff.cs == ST_HUNT) ? 1'b0 : (ph ^ st_ff.p0);
                        if (car) begin
                            if (st_ff.cs == ST_HUNT) begin
                                nxt_st.p0 = ph;
                                nxt_st.start = 1'b1;
                                nxt_st.cs = ST_RX;
                            end
                            nxt_st.rxsh[st_ff.rxn] = rbit;
                            nxt_st.rxn = st_ff.rxn + 3'h1;
                            if (st_ff.rxn == 3'h7) begin
                                if (nxt_st.pend) begin
                                    nxt_st.ovf = 1'b1;
                                end
                                nxt_st.pend = 1'b1;
                                nxt_st.pbyte = nxt_st.rxsh;
                                nxt_st.rxsh = 8'h00;
                            end
                        end else if (st_ff.cs == ST_RX) begin
                            nxt_st.endp = 1'b1;
                            nxt_st.cs = ST_HUNT;
                            nxt_st.rxn = 3'h0;
                            nxt_st.rxsh = 8'h00;
                            if (st_ff.rxn != 3'h0) begin
                                if (nxt_st.pend) begin
                                    nxt_st.ovf = 1'b1;
                                end
                                nxt_st.pend = 1'b1;
                                nxt_st.pbyte = st_ff.rxsh;
                            end
                        end
                    end
                end
            end
            ST_TX: begin
                if (st_ff.txn == 4'h0) begin
                    if (f_out_valid && !spi_pop) begin
                        tx_take = 1'b1;
                        nxt_st.txsh = f_out_data;
                        nxt_st.txn = 4'h8;
                        nxt_st.fcnt = 8'h00;
                        nxt_st.mod = f_out_data[0];
                    end else if (!f_out_valid) begin
                        nxt_st.cs = ST_IDLE;
                        nxt_st.mod = 1'b0;
                    end
                end else if (fc_tick_in) begin
                    nxt_st.fcnt = st_ff.fcnt + 8'h01;
                    if (st_ff.fcnt == tl - 8'h01) begin
                        nxt_st.fcnt = 8'h00;
                        nxt_st.txsh = {1'b0, st_ff.txsh[7:1]};
                        nxt_st.txn = st_ff.txn - 4'h1;
                        if (st_ff.txn != 4'h1) begin
                            nxt_st.mod = st_ff.txsh[1];
                        end
                    end
                end
            end
            default: begin
                nxt_st.cs = ST_IDLE;
            end
        endcase
        if (cmd_tx && stream) begin
            nxt_st.cs = ST_TX;
            nxt_st.txn = 4'h0;
            nxt_st.fcnt = 8'h00;
        end
        if (!stream) begin
            nxt_st.cs = ST_IDLE;
            nxt_st.mod = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
            st_ff.pin.ss <= 2'h3;
            st_ff.spi.first <= 1'b1;
            st_ff.regs[`A_IO1] <= `IO1_RST;
            st_ff.cs <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign miso_out     = st_ff.miso;
    assign miso_oe_out  = st_ff.moe;
    assign tx_mod_out   = st_ff.mod;
    assign tx_ook_out   = st_ff.ook;
    assign rx_start_out = st_ff.start;
    assign rx_end_out   = st_ff.endp;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    a_subc_range: assert property (sl inside {8'h04, 8'h08, 8'h10})
        else $error("sub-carrier period out of range");
    a_report_span: assert property (rl >= sl && rl <= (sl << 3))
        else $error("reporting period span out of range");
    a_example_cfg: assert property (scf == 2'h1 && scp == 2'h1 |-> rl == 8'h10)
        else $error("01b settings do not give 16 carrier cycles");
    a_tx_base: assert property (st_ff.regs[`A_STREAM][`STR_STX] == 3'h0 |-> tl == 8'h80)
        else $error("000b does not give 128 carrier cycles");
    a_rx_start: assert property (rx_start_out |-> st_ff.cs == ST_RX && st_ff.rxn == 3'h1
                                 && st_ff.rxsh[0] == 1'b0 && $past(st_ff.cs) == ST_HUNT)
        else $error("receive start without first bit stored");
    a_rx_end: assert property (rx_end_out |-> st_ff.cs == ST_HUNT && $past(st_ff.cs) == ST_RX
                               && $past(st_ff.edges) < nper + 8'h01)
        else $error("receive end without a silent period");
    a_mod_only_tx: assert property (tx_mod_out |-> $past(st_ff.cs) == ST_TX)
        else $error("modulation outside transmit");
    a_tx_hold: assert property (st_ff.cs == ST_TX && st_ff.txn > 4'h1 && stream
                                && !(fc_tick_in && st_ff.fcnt == tl - 8'h01) && !cmd_tx
                                |=> tx_mod_out == $past(tx_mod_out))
        else $error("transmit bit changed inside its period");
    a_set_default: assert property (cmd_def |=> st_ff.regs[`A_STREAM] == `REG_RST
                                    && st_ff.regs[`A_OPCTL] == $past(st_ff.regs[`A_OPCTL]))
        else $error("set default handled wrong registers");
    a_cfg_write: assert property (wr_en |=> st_ff.regs[$past(st_ff.spi.addr)]
                                  == $past(byte_b))
        else $error("configuration write not stored");

    c_rx_start: cover property (rx_start_out);
    c_rx_end: cover property (rx_end_out);
    c_tx_run: cover property (tx_take ##[1:300] tx_mod_out);
    c_set_def: cover property (cmd_def);

endmodule // bpsk_stream_codec
`default_nettype wire

// ===== logic/codec_regs.svh
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_IO1 6'h00
`define A_OPCTL 6'h02
`define A_MODE 6'h03
`define A_STREAM 6'h08
`define A_FSTAT1 6'h1A
`define A_FSTAT2 6'h1B

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define MODE_OM 7:3
`define MODE_OOK 0
`define OM_STREAM 5'h0F
`define STR_SCF 6:5
`define STR_SCP 4:3
`define STR_STX 2:0
`define IO1_RST 8'h08
`define REG_RST 8'h00

// ----------------------------------------
// Timing in carrier cycles
// ----------------------------------------
`define SUBC_BASE 8'h10
`define SUBC_MIN 8'h04
`define TX_BASE 8'h80

// ----------------------------------------
// SPI framing and direct commands
// ----------------------------------------
`define OP_WR 2'h0
`define OP_RD 2'h1
`define OP_FIFO 2'h2
`define OP_CMD 2'h3
`define CMD_SET_DEFAULT 6'h01
`define CMD_TX_CRC 6'h04
`define CMD_TX_NOCRC 6'h05

`endif

// ===== logic/codec_pkg.sv
`default_nettype none
package codec_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HUNT = 4'h2,
        ST_RX   = 4'h4,
        ST_TX   = 4'h8
    } cstate_t;

    typedef struct packed {
        logic [1:0] ss;
        logic [2:0] sck;
        logic [1:0] mosi;
        logic [2:0] rx;
    } pins_t;

    typedef struct packed {
        logic       first;
        logic [2:0] bitcnt;
        logic [1:0] op;
        logic [5:0] addr;
        logic [7:0] shi;
        logic [7:0] sho;
    } spi_t;

    typedef struct packed {
        pins_t            pin;
        spi_t             spi;
        logic [63:0][7:0] regs;
        cstate_t          cs;
        logic [7:0]       fcnt;
        logic [7:0]       agree;
        logic [7:0]       edges;
        logic             p0;
        logic [7:0]       rxsh;
        logic [2:0]       rxn;
        logic             pend;
        logic [7:0]       pbyte;
        logic             ovf;
        logic [7:0]       txsh;
        logic [3:0]       txn;
        logic             miso;
        logic             moe;
        logic             mod;
        logic             ook;
        logic             start;
        logic             endp;
    } codec_st_t;

endpackage
`default_nettype wire

// ===== logic/stream_fifo.sv
`default_nettype none
module stream_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    input  wire logic                   in_valid_in,
    output logic                        in_ready_out,
    input  wire logic [W-1:0]           in_data_in,
    output logic                        out_valid_out,
    input  wire logic                   out_ready_in,
    output logic [W-1:0]                out_data_out,
    output logic [$clog2(D+1)-1:0]      count_out
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [CW-1:0]       cnt;
    } fifo_st_t;

    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic     push;
    logic     pop;

    assign in_ready_out  = st_ff.cnt != CW'(D);
    assign out_valid_out = st_ff.cnt != '0;
    assign out_data_out  = st_ff.mem[st_ff.rd];
    assign count_out     = st_ff.cnt;

    always_comb begin
        nxt_st = st_ff;
        push = in_valid_in & in_ready_out;
        pop = out_valid_out & out_ready_in;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data_in;
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // stream_fifo
`default_nettype wire

// ===== bench/tag_model.sv
`default_nettype none
module tag_model (
    input  wire logic       clk_sys_in,
    input  wire logic       tx_mod_in,
    input  wire logic [7:0] len_in,
    output logic            subc_out,
    output logic [7:0]      got_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int k;
    // ----------------------------------------
    // Tag answer and reader frame capture
    // ----------------------------------------
    // The tag only loads the field while answering, so the line is quiet between bursts.
    initial subc_out = 1'b0;
    task automatic burst(input int na, input int nb);
        for (int i = 0; i < (na + nb) * 16; i++) begin
            @(negedge clk_sys_in);
            subc_out = i[2] ^ (i >= na * 16);
        end
        @(negedge clk_sys_in);
        subc_out = 1'b0;
    endtask
    // Sampling mid-bit keeps the capture immune to a few cycles of launch latency.
    always @(posedge tx_mod_in) begin
        repeat (len_in / 2) @(posedge clk_sys_in);
        for (k = 0; k < 8; k++) begin
            got_out[k] = tx_mod_in;
            repeat (len_in) @(posedge clk_sys_in);
        end
    end
endmodule // tag_model
`default_nettype wire

// ===== bench/bpsk_stream_mode_codec_tb.sv
`include "codec_regs.svh"
`default_nettype none
module bpsk_stream_mode_codec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       ss_n = 1'b1;
    logic       sclk = 1'b0;
    logic       mosi = 1'b0;
    logic       miso, moe, mod, ook, rs, re, subc;
    logic [7:0] got, r;
    logic [7:0] tlen = 8'h80;
    int         miscompares = 0;
    int         n_checks = 0;
    always #20 clk_sys = ~clk_sys;
    bpsk_stream_codec u_dut (.clk_sys_in(clk_sys), .rst_in(rst), .fc_tick_in(1'b1),
        .rx_subc_in(subc), .ss_n_in(ss_n), .sclk_in(sclk), .mosi_in(mosi),
        .miso_out(miso), .miso_oe_out(moe), .tx_mod_out(mod), .tx_ook_out(ook),
        .rx_start_out(rs), .rx_end_out(re));
    tag_model u_tag (.clk_sys_in(clk_sys), .tx_mod_in(mod), .len_in(tlen),
        .subc_out(subc), .got_out(got));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Half an SCLK period is five system clocks, well under the oversampling limit.
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input int nb);
        ss_n = 1'b0;
        tick(4);
        check({7'h0, moe}, 8'h01);
        for (int n = 0; n < nb; n++) begin
            for (int i = 7; i >= 0; i--) begin
                sclk = 1'b1;
                mosi = (n == 0) ? b0[i] : b1[i];
                tick(5);
                sclk = 1'b0;
                r = {r[6:0], miso};
                tick(5);
            end
        end
        tick(4);
        ss_n = 1'b1;
        tick(6);
        check({7'h0, moe}, 8'h00);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        frame({`OP_WR, a}, d, 2);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        frame({`OP_RD, a}, 8'h00, 2);
        check(r, exp);
    endtask
    task automatic wait_pulse(input bit sel, input int lim);
        int i;
        for (i = 0; i < lim && (sel ? re : rs) !== 1'b1; i++) tick(1);
        check({7'h0, (sel ? re : rs)}, 8'h01);
        if (i == lim) end_of_test();
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        tick(1);
        rst = 1'b0;
        tick(4);
        rd(`A_IO1, `IO1_RST);
        rd(`A_MODE, 8'h00);
        wr(`A_OPCTL, 8'h5A);
        wr(`A_STREAM, 8'h7F);
        rd(`A_STREAM, 8'h7F);
        wr(`A_FSTAT1, 8'hFF);
        rd(`A_FSTAT1, 8'h00);
        rd(6'h3F, 8'h00);
        frame({`OP_CMD, `CMD_SET_DEFAULT}, 8'h00, 1);
        rd(`A_OPCTL, 8'h5A);
        rd(`A_STREAM, 8'h00);
        frame(8'h80, 8'h00, 34);
        rd(`A_FSTAT1, 8'h20);
        rd(`A_FSTAT2, 8'h80);
        rd(`A_FSTAT2, 8'h00);
        for (int i = 0; i < 32; i++) frame(8'h81, 8'h00, 2);
        rd(`A_FSTAT1, 8'h00);
        $display("registers and buffer test done");
        wr(`A_STREAM, 8'h28);
        wr(`A_MODE, {`OM_STREAM, 3'h0});
        // Two cycles put the tag in phase with the reporting grid; at a quarter
        // period offset the agreement count sits at half and the phase is ambiguous.
        fork
            begin
                tick(2);
                u_tag.burst(4, 11);
            end
            wait_pulse(1'b0, 600);
        join
        wait_pulse(1'b1, 100);
        rd(`A_FSTAT1, 8'h02);
        frame(8'h81, 8'h00, 2);
        check(r & 8'hE3, 8'hE0);
        frame(8'h81, 8'h00, 2);
        check(r & 8'h1F, 8'h1F);
        $display("receive test done");
        for (int k = 0; k < 2; k++) begin
            wr(`A_MODE, {`OM_STREAM, 2'h0, k[0]});
            wr(`A_STREAM, {5'h0, k[2:0]});
            tlen = `TX_BASE >> k;
            frame(8'h80, k[0] ? 8'h3D : 8'hA5, 2);
            frame({`OP_CMD, k[0] ? `CMD_TX_CRC : `CMD_TX_NOCRC}, 8'h00, 1);
            check({7'h0, ook}, {7'h0, k[0]});
            tick(9 * int'(tlen) + 40);
            check(got, k[0] ? 8'h3D : 8'hA5);
            check({7'h0, mod}, 8'h00);
        end
        $display("transmit test done");
        end_of_test();
    end
endmodule // bpsk_stream_mode_codec_tb
`default_nettype wire
